// ==== pmd_map.svh ====
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PMD_ADDR_W          4
`define PMD_DATA_W          32
`define PMD_CFG_OFFSET      4'h0
`define PMD_STATUS_OFFSET   4'h4
`define PMD_CFG_RESET       3'h0
`define PMD_CFG_MODE_BIT    0
`define PMD_CFG_GATE_BIT    1
`define PMD_CFG_SEL_BIT     2
`define PMD_CNT_W           3
`define PMD_CNT_RESET       3'h0

`endif

// ==== pmd_pkg.sv ====
package pmd_pkg;

	typedef enum logic [2:0]
	{
		PMD_ST_HOLD  = 3'b001,
		PMD_ST_GATED = 3'b010,
		PMD_ST_RUN   = 3'b100
	} pmd_state_type;

	typedef struct packed
	{
		logic reset_release_clock_select;
		logic release_gate_enable;
		logic divider_mode_enable;
	} pmd_cfg_type;

	typedef struct packed
	{
		logic output_port_four;
		logic output_port_three;
		logic output_port_two;
		logic output_port_one;
		logic output_port_zero;
	} pmd_clk_out_type;

endpackage : pmd_pkg

// ==== pmd_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage synchroniser with rising-edge pulse
// ----------------------------------------------------------------------------
module pmd_sync
#(
	parameter logic RESET_VALUE = 1'b0
)
(
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic async_in,
	output logic      level_out,
	output logic      rise_out
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_reg <= RESET_VALUE;
			stage2_reg <= RESET_VALUE;
			stage3_reg <= RESET_VALUE;
		end
		else
		begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	assign level_out = stage2_reg;
	assign rise_out  = stage2_reg & ~stage3_reg;

endmodule : pmd_sync

`default_nettype wire

// ==== pmd_divider.sv ====
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

`include "pmd_map.svh"

// Functional notes
// - Legacy divider mode runs only when mode enable is set; default off.
// - Divider mode accepts exactly two input clocks; four need two instances.
// - Primary clock input is first divider clock; feedback input is second.
// - Divider reset forces every output low at once, without a clock.
// - Reset removal takes effect on a clock edge; toggling starts after it.
// - Select chooses first or second clock for reset removal; first default.
// - With release gate set, divided outputs stay low until release asserted.
// - Divided outputs start on a first-clock edge once release is asserted.
// - Output zero carries an undivided copy of the second clock.
module phase_matched_divider
	import pmd_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	input  wire logic                   primary_clock_input,
	input  wire logic                   feedback_clock_input,
	input  wire logic                   divider_reset,
	input  wire logic                   release_input,
	input  wire logic [`PMD_ADDR_W-1:0] reg_addr,
	input  wire logic [`PMD_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic      [`PMD_DATA_W-1:0] reg_rdata,
	output logic                        output_port_zero,
	output logic                        output_port_one,
	output logic                        output_port_two,
	output logic                        output_port_three,
	output logic                        output_port_four
);

	// ------------------------------------------------------------------------
	// Reset combination
	// ------------------------------------------------------------------------
	// The divider reset pin clears the clock path asynchronously, so the
	// outputs drop low without waiting for any edge.
	logic div_nrst;

	assign div_nrst = nrst & ~divider_reset;

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	logic first_divider_clock;
	logic first_rise;
	logic second_divider_clock;
	logic second_rise;
	logic release_level;
	logic reset_held;

	// Only two clock inputs exist in this mode.
	pmd_sync #(.RESET_VALUE(1'b0)) u_first_sync
	(
		.core_clk  (core_clk),
		.nrst      (div_nrst),
		.async_in  (primary_clock_input),
		.level_out (first_divider_clock),
		.rise_out  (first_rise)
	);

	pmd_sync #(.RESET_VALUE(1'b0)) u_second_sync
	(
		.core_clk  (core_clk),
		.nrst      (div_nrst),
		.async_in  (feedback_clock_input),
		.level_out (second_divider_clock),
		.rise_out  (second_rise)
	);

	pmd_sync #(.RESET_VALUE(1'b0)) u_release_sync
	(
		.core_clk  (core_clk),
		.nrst      (div_nrst),
		.async_in  (release_input),
		.level_out (release_level),
		.rise_out  ()
	);

	// The reset synchroniser is set while the divider reset is active and
	// shifts in zero after release.
	pmd_sync #(.RESET_VALUE(1'b1)) u_reset_sync
	(
		.core_clk  (core_clk),
		.nrst      (div_nrst),
		.async_in  (1'b0),
		.level_out (reset_held),
		.rise_out  ()
	);

	// ------------------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------------------
	pmd_cfg_type cfg_reg;
	pmd_cfg_type cfg_next;

	always_comb
	begin
		cfg_next = cfg_reg;
		if (reg_write && (reg_addr == `PMD_CFG_OFFSET))
		begin
			cfg_next.divider_mode_enable =
				reg_wdata[`PMD_CFG_MODE_BIT];
			cfg_next.release_gate_enable =
				reg_wdata[`PMD_CFG_GATE_BIT];
			cfg_next.reset_release_clock_select =
				reg_wdata[`PMD_CFG_SEL_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cfg_reg <= `PMD_CFG_RESET;
		else
			cfg_reg <= cfg_next;
	end

	// ------------------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------------------
	pmd_state_type state_reg;
	pmd_state_type state_next;
	logic          sel_rise;

	// Reset removal is taken on the rising edge of the chosen clock.
	assign sel_rise = cfg_reg.reset_release_clock_select ? second_rise
		: first_rise;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PMD_ST_HOLD:
			begin
				if (cfg_reg.divider_mode_enable && !reset_held
					&& sel_rise)
				begin
					if (cfg_reg.release_gate_enable)
						state_next = PMD_ST_GATED;
					else
						state_next = PMD_ST_RUN;
				end
			end
			PMD_ST_GATED:
			begin
				if (!cfg_reg.divider_mode_enable)
					state_next = PMD_ST_HOLD;
				else if (release_level && first_rise)
					state_next = PMD_ST_RUN;
			end
			PMD_ST_RUN:
			begin
				if (!cfg_reg.divider_mode_enable)
					state_next = PMD_ST_HOLD;
			end
			default:
				state_next = PMD_ST_HOLD;
		endcase
	end

	always_ff @(posedge core_clk or negedge div_nrst)
	begin
		if (!div_nrst)
			state_reg <= PMD_ST_HOLD;
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------------------
	// Clock outputs
	// ------------------------------------------------------------------------
	logic [`PMD_CNT_W-1:0] phase_reg;
	logic [`PMD_CNT_W-1:0] phase_next;
	pmd_clk_out_type       out_reg;
	pmd_clk_out_type       out_next;
	logic                  active;
	logic                  divided_on;

	assign active     = (state_reg != PMD_ST_HOLD);
	assign divided_on = (state_reg == PMD_ST_RUN) ||
		((state_reg == PMD_ST_GATED) && release_level && first_rise);

	always_comb
	begin
		phase_next = phase_reg;
		out_next   = out_reg;
		if (!active)
		begin
			out_next   = '0;
			phase_next = `PMD_CNT_RESET;
		end
		else
		begin
			out_next.output_port_zero = second_divider_clock;
			out_next.output_port_one  = first_divider_clock;
			// Divided outputs change only on first-clock rising edges, in
			// the same cycle the undivided copy rises, so they stay aligned.
			if (divided_on && first_rise)
			begin
				out_next.output_port_two   = ~phase_reg[0];
				out_next.output_port_three = ~phase_reg[1];
				out_next.output_port_four  = ~phase_reg[2];
				phase_next = phase_reg + `PMD_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge div_nrst)
	begin
		if (!div_nrst)
		begin
			phase_reg <= `PMD_CNT_RESET;
			out_reg   <= '0;
		end
		else
		begin
			phase_reg <= phase_next;
			out_reg   <= out_next;
		end
	end

	assign output_port_zero  = out_reg.output_port_zero;
	assign output_port_one   = out_reg.output_port_one;
	assign output_port_two   = out_reg.output_port_two;
	assign output_port_three = out_reg.output_port_three;
	assign output_port_four  = out_reg.output_port_four;

	// ------------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------------
	logic [`PMD_DATA_W-1:0] rdata_next;

	always_comb
	begin
		rdata_next = '0;
		if (reg_read)
		begin
			if (reg_addr == `PMD_CFG_OFFSET)
				rdata_next = {29'h0, cfg_reg};
			else if (reg_addr == `PMD_STATUS_OFFSET)
				rdata_next = {24'h0, phase_reg, state_reg, reset_held,
					release_level};
			else
				rdata_next = '0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= '0;
		else
			reg_rdata <= rdata_next;
	end

endmodule : phase_matched_divider

`default_nettype wire

// ==== pmd_divider_props.sv ====
`timescale 1ns/10ps
`default_nettype none

`include "pmd_map.svh"

module pmd_divider_props
(
	input wire logic                   core_clk,
	input wire logic                   nrst,
	input wire logic                   primary_clock_input,
	input wire logic                   feedback_clock_input,
	input wire logic                   divider_reset,
	input wire logic [`PMD_ADDR_W-1:0] reg_addr,
	input wire logic [`PMD_DATA_W-1:0] reg_wdata,
	input wire logic                   reg_write,
	input wire logic                   reg_read,
	input wire logic [`PMD_DATA_W-1:0] reg_rdata,
	input wire logic                   output_port_zero,
	input wire logic                   output_port_one,
	input wire logic                   output_port_two,
	input wire logic                   output_port_three,
	input wire logic                   output_port_four
);
	logic       mode_reg;
	logic [4:0] outs;

	assign outs = {output_port_four, output_port_three, output_port_two,
		output_port_one, output_port_zero};

	// Mirrors the mode bit as software last wrote it.
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			mode_reg <= 1'b0;
		else if (reg_write && reg_addr == `PMD_CFG_OFFSET)
			mode_reg <= reg_wdata[`PMD_CFG_MODE_BIT];
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_rst_low;
		divider_reset |-> outs == 5'h00;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("outputs high in reset");

	property p_mode_off;
		!mode_reg [*3] |-> outs == 5'h00;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("outputs with mode off");

	property p_one_copy;
		$rose(output_port_one) |-> $past(primary_clock_input, 3);
	endproperty
	a_one_copy: assert property (p_one_copy) else $error("port one not a copy");

	property p_zero_copy;
		$rose(output_port_zero) |-> $past(feedback_clock_input, 3);
	endproperty
	a_zero_copy: assert property (p_zero_copy) else $error("port zero wrong");

	property p_ph2;
		$rose(output_port_two) |-> $rose(output_port_one);
	endproperty
	a_ph2: assert property (p_ph2) else $error("half clock out of phase");

	property p_ph3;
		$rose(output_port_three) |-> $rose(output_port_two);
	endproperty
	a_ph3: assert property (p_ph3) else $error("quarter out of phase");

	property p_ph4;
		$rose(output_port_four) |-> $rose(output_port_three);
	endproperty
	a_ph4: assert property (p_ph4) else $error("eighth out of phase");

	property p_rd_idle;
		!$past(reg_read) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

	property p_unmapped;
		reg_read && reg_addr != `PMD_CFG_OFFSET &&
			reg_addr != `PMD_STATUS_OFFSET |=> reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read data");

	cover property ($rose(output_port_four));
	cover property ($rose(output_port_zero));
	cover property (reg_read ##1 reg_rdata != 32'h0);
endmodule : pmd_divider_props

bind phase_matched_divider pmd_divider_props u_props (.*);

`default_nettype wire

// ==== pmd_fabric.sv ====
`timescale 1ns/10ps
`default_nettype none

// Fabric side: makes both input clocks, a half period of zero stops one low.
module pmd_fabric
(
	input  wire logic       core_clk,
	input  wire logic [2:0] half_a,
	input  wire logic [2:0] half_b,
	input  wire logic       go_rel,
	output logic            primary_clock_input,
	output logic            feedback_clock_input,
	output logic            release_input
);
	int ca = 0;
	int cb = 0;

	initial primary_clock_input = 1'b0;
	initial feedback_clock_input = 1'b0;
	initial release_input = 1'b0;

	always @(posedge core_clk)
	begin
		ca <= (ca + 1 >= half_a) ? 0 : ca + 1;
		cb <= (cb + 1 >= half_b) ? 0 : cb + 1;
		if (half_a == 3'h0)
			primary_clock_input <= 1'b0;
		else if (ca + 1 >= half_a)
			primary_clock_input <= !primary_clock_input;
		if (half_b == 3'h0)
			feedback_clock_input <= 1'b0;
		else if (cb + 1 >= half_b)
			feedback_clock_input <= !feedback_clock_input;
		release_input <= go_rel;
	end
endmodule : pmd_fabric

`default_nettype wire

// ==== phase_matched_clock_divider_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module phase_matched_clock_divider_tb_top;
	logic        core_clk, nrst, divider_reset, reg_write, reg_read, go_rel;
	logic        primary_clock_input, feedback_clock_input, release_input;
	logic        output_port_zero, output_port_one, output_port_two;
	logic        output_port_three, output_port_four;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0]  half_a, half_b, cfg;
	logic [4:0]  outs, prev;
	int          seed, err_total, checked, cyc, n, cnt[5];

	assign outs = {output_port_four, output_port_three, output_port_two,
		output_port_one, output_port_zero};

	phase_matched_divider dut (.*);
	pmd_fabric u_fab (.*);

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Counts rising edges of every output.
	always @(posedge core_clk)
	begin
		for (int i = 0; i < 5; i++)
			if (outs[i] && !prev[i])
				cnt[i]++;
		prev <= outs;
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic run(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : run

	task automatic clr();
		foreach (cnt[i])
			cnt[i] = 0;
	endtask : clr

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e, string nm);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		chk(nm, reg_rdata, e);
		@(posedge core_clk);
	endtask : rd

	task automatic tally_and_finish();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		seed = 83371;
		{nrst, reg_write, reg_read, go_rel, half_a, half_b} = '0;
		{err_total, checked, cyc, prev, reg_addr, reg_wdata} = '0;
		divider_reset = 1'b1;
		clr();
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rd(4'h4, 32'h6, "status");
		wr(4'h8, 32'h7);
		rd(4'h8, 32'h0, "unmapped");
		rd(4'h0, 32'h0, "cfg");
		half_a <= 3'h3;
		half_b <= 3'h2;
		divider_reset <= 1'b0;
		clr();
		run(200);
		chk("mode off", cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4], 0);
		$display("test registers done");
		for (int k = 0; k < 4; k++)
		begin
			@(posedge core_clk);
			cfg = {k[1:0], 1'b1};
			divider_reset <= 1'b1;
			go_rel <= 1'b0;
			half_a <= 3'h2 + 3'($random(seed) & 3);
			half_b <= 3'h0;
			wr(4'h0, {29'h0, cfg});
			rd(4'h0, {29'h0, cfg}, "cfg");
			divider_reset <= 1'b0;
			clr();
			run(100);
			chk("start sel", 32'(cnt[1] != 0), 32'(!cfg[2]));
			half_b <= 3'h2 + 3'($random(seed) & 3);
			run(100);
			clr();
			run(100);
			// The window has a random phase, so only activity is exact here.
			chk("gated", 32'(cnt[2] + cnt[3] + cnt[4] != 0), 32'(!cfg[1]));
			chk("ungated one", 32'(cnt[1] != 0), 1);
			go_rel <= 1'b1;
			clr();
			n = 0;
			while (cnt[4] == 0 && n < 400)
			begin
				run(1);
				n++;
			end
			chk("released", 32'(cnt[4]), 1);
			clr();
			n = 0;
			while (cnt[1] < 63 && n < 800)
			begin
				run(1);
				n++;
			end
			chk("period", n, 126 * half_a);
			chk("half", cnt[2], 31);
			chk("quarter", cnt[3], 15);
			chk("eighth", cnt[4], 7);
			#2 divider_reset = 1'b1;
			#1 chk("async low", outs, 5'h00);
			$display("test %0d done", k);
		end
		// Restart with gate and feedback select, then clear the mode bit.
		@(posedge core_clk);
		divider_reset <= 1'b0;
		clr();
		run(100);
		chk("restart", 32'(cnt[4] != 0), 1);
		@(posedge core_clk);
		wr(4'h0, 32'h0);
		rd(4'h0, 32'h0, "cfg clear");
		run(10);
		clr();
		run(50);
		chk("mode clear", outs, 5'h00);
		chk("mode clear edges", cnt[1] + cnt[4], 0);
		$display("test mode clear done");
		tally_and_finish();
	end
endmodule : phase_matched_clock_divider_tb_top

`default_nettype wire
